// *** logic/ocs_pkg.sv ***
// Constants and types for the output clock select and sync enable block
package ocs_pkg;

    localparam logic [7:0] OCS_ADDR_OUT_ONE  = 8'h62;
    localparam logic [7:0] OCS_ADDR_SYNC_EN  = 8'h63;

    localparam logic [7:0] OCS_OUT_ONE_RESET = 8'h80;
    localparam logic [7:0] OCS_SYNC_RESET    = 8'hC0;

    localparam int         OCS_SEL_MSB       = 7;
    localparam int         OCS_SEL_LSB       = 4;
    localparam int         OCS_MFRAME_BIT    = 7;
    localparam int         OCS_FRAME_BIT     = 6;

    localparam logic [7:0] OCS_OUT_ONE_MASK  = 8'hF0;
    localparam logic [7:0] OCS_SYNC_MASK     = 8'hC0;

    localparam logic [3:0] OCS_CODE_OFF      = 4'h0;
    localparam logic [3:0] OCS_CODE_2K       = 4'h1;
    localparam logic [3:0] OCS_CODE_PLLA_D2  = 4'h2;
    localparam logic [3:0] OCS_CODE_SPARE    = 4'h3;
    localparam logic [3:0] OCS_CODE_SYNTH_A  = 4'h4;
    localparam logic [3:0] OCS_CODE_PLLA     = 4'h5;
    localparam logic [3:0] OCS_CODE_PLLA_D16 = 4'h6;
    localparam logic [3:0] OCS_CODE_PLLA_D12 = 4'h7;
    localparam logic [3:0] OCS_CODE_PLLA_D8  = 4'h8;
    localparam logic [3:0] OCS_CODE_PLLA_D6  = 4'h9;
    localparam logic [3:0] OCS_CODE_PLLA_D4  = 4'hA;
    localparam logic [3:0] OCS_CODE_PLLB_D64 = 4'hB;
    localparam logic [3:0] OCS_CODE_PLLB_D48 = 4'hC;
    localparam logic [3:0] OCS_CODE_PLLB_UNK = 4'hD;
    localparam logic [3:0] OCS_CODE_PLLB_D8  = 4'hE;
    localparam logic [3:0] OCS_CODE_PLLB_D4  = 4'hF;

    localparam logic [6:0] OCS_DIV_1         = 7'h01;
    localparam logic [6:0] OCS_DIV_2         = 7'h02;
    localparam logic [6:0] OCS_DIV_4         = 7'h04;
    localparam logic [6:0] OCS_DIV_6         = 7'h06;
    localparam logic [6:0] OCS_DIV_8         = 7'h08;
    localparam logic [6:0] OCS_DIV_12        = 7'h0C;
    localparam logic [6:0] OCS_DIV_16        = 7'h10;
    localparam logic [6:0] OCS_DIV_48        = 7'h30;
    localparam logic [6:0] OCS_DIV_64        = 7'h40;

    typedef enum logic [2:0]
    {
        OCS_SRC_OFF,
        OCS_SRC_2K,
        OCS_SRC_SYNTH_A,
        OCS_SRC_PLL_A,
        OCS_SRC_PLL_B
    } ocs_src_e;

endpackage : ocs_pkg

// *** logic/ocs_sel_if.sv ***
// Carrier between the register file and the selector decoder
`timescale 1ns/1ps
interface ocs_sel_if;
    import ocs_pkg::*;

    logic     [3:0] code;
    ocs_src_e       source;
    logic     [6:0] divide;

    modport regs (output code, input source, input divide);
    modport dec  (input code, output source, output divide);
endinterface : ocs_sel_if

// *** logic/ocs_decode.sv ***
// Decoder from output-one selector code to source and divide ratio
`timescale 1ns/1ps
module ocs_decode
    import ocs_pkg::*;
(
    ocs_sel_if.dec sel // Selector code in, source and ratio out
);

    always_comb
    begin
        sel.source = OCS_SRC_OFF;
        sel.divide = OCS_DIV_1;
        case (sel.code)
            OCS_CODE_2K:       sel.source = OCS_SRC_2K;
            OCS_CODE_PLLA_D2:
            begin
                sel.source = OCS_SRC_PLL_A;
                sel.divide = OCS_DIV_2;
            end
            OCS_CODE_SYNTH_A:  sel.source = OCS_SRC_SYNTH_A;
            OCS_CODE_PLLA:     sel.source = OCS_SRC_PLL_A;
            OCS_CODE_PLLA_D16:
            begin
                sel.source = OCS_SRC_PLL_A;
                sel.divide = OCS_DIV_16;
            end
            OCS_CODE_PLLA_D12:
            begin
                sel.source = OCS_SRC_PLL_A;
                sel.divide = OCS_DIV_12;
            end
            OCS_CODE_PLLA_D8:
            begin
                sel.source = OCS_SRC_PLL_A;
                sel.divide = OCS_DIV_8;
            end
            OCS_CODE_PLLA_D6:
            begin
                sel.source = OCS_SRC_PLL_A;
                sel.divide = OCS_DIV_6;
            end
            OCS_CODE_PLLA_D4:
            begin
                sel.source = OCS_SRC_PLL_A;
                sel.divide = OCS_DIV_4;
            end
            OCS_CODE_PLLB_D64:
            begin
                sel.source = OCS_SRC_PLL_B;
                sel.divide = OCS_DIV_64;
            end
            OCS_CODE_PLLB_D48:
            begin
                sel.source = OCS_SRC_PLL_B;
                sel.divide = OCS_DIV_48;
            end
            OCS_CODE_PLLB_D8:
            begin
                sel.source = OCS_SRC_PLL_B;
                sel.divide = OCS_DIV_8;
            end
            OCS_CODE_PLLB_D4:
            begin
                sel.source = OCS_SRC_PLL_B;
                sel.divide = OCS_DIV_4;
            end
            // Spare and undefined ratio codes park the pin quietly
            default:
            begin
                sel.source = OCS_SRC_OFF;
                sel.divide = OCS_DIV_1;
            end
        endcase
    end

endmodule : ocs_decode

// *** logic/ocs_top.sv ***
// Output-one clock selector and sync output enables with register port
`timescale 1ns/1ps

// Summary of operation
// - Upper nibble of output-one register selects clock on output one.
// - Code 0 off, 1 is 2 kHz, 4 synth clock, 5 undivided PLL A.
// - Codes 6-A divide PLL A; B, C, E, F divide PLL B by 64,48,8,4.
// - Output-one register is read/write, resets to 0x80, PLL A over eight.
// - Sync register bit 7 enables multiframe pulse, bit 6 frame pulse; reset 0xC0.
module ocs_top
    import ocs_pkg::*;
(
    input  wire logic       mclk,                 // System clock, 25 MHz
    input  wire logic       reset,                // Asynchronous reset, active high
    input  wire logic [7:0] reg_addr,             // Register address
    input  wire logic [7:0] reg_wdata,            // Write data
    input  wire logic       reg_wr,               // Write strobe, one cycle
    input  wire logic       reg_rd,               // Read strobe, one cycle
    output logic      [7:0] reg_rdata,            // Read data, valid cycle after strobe
    input  wire logic       frame_pulse_in,       // 8 kHz frame pulse from generator
    input  wire logic       multiframe_pulse_in,  // 2 kHz multiframe pulse from generator
    output ocs_src_e        clock_output_one_src, // Source feeding output one
    output logic      [6:0] clock_output_one_div, // Divide ratio on that source
    output logic            frame_pulse_out,      // Gated frame pulse
    output logic            multiframe_pulse_out  // Gated multiframe pulse
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register file

    logic [7:0] out_one_reg;
    logic [7:0] out_one_next;
    logic [7:0] sync_reg;
    logic [7:0] sync_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    function automatic logic [7:0] ocs_read(input logic [7:0] addr,
                                            input logic [7:0] one,
                                            input logic [7:0] sync);
        if (addr == OCS_ADDR_OUT_ONE)
            return one & OCS_OUT_ONE_MASK;
        else if (addr == OCS_ADDR_SYNC_EN)
            return sync & OCS_SYNC_MASK;
        else
            return 8'h00;
    endfunction : ocs_read

    always_comb
    begin
        out_one_next = out_one_reg;
        sync_next    = sync_reg;
        rdata_next   = rdata_reg;
        if (reg_wr && reg_addr == OCS_ADDR_OUT_ONE)
            out_one_next = reg_wdata & OCS_OUT_ONE_MASK;
        else if (reg_wr && reg_addr == OCS_ADDR_SYNC_EN)
            sync_next = reg_wdata & OCS_SYNC_MASK;
        if (reg_rd)
            rdata_next = ocs_read(reg_addr, out_one_reg, sync_reg);
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            out_one_reg <= OCS_OUT_ONE_RESET;
            sync_reg    <= OCS_SYNC_RESET;
            rdata_reg   <= 8'h00;
        end
        else
        begin
            out_one_reg <= out_one_next;
            sync_reg    <= sync_next;
            rdata_reg   <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Selector decode and output registers

    ocs_sel_if sel_bus ();

    assign sel_bus.code = out_one_reg[OCS_SEL_MSB:OCS_SEL_LSB];

    ocs_decode u_decode
    (
        .sel (sel_bus.dec)
    );

    ocs_src_e   src_reg;
    ocs_src_e   src_next;
    logic [6:0] div_reg;
    logic [6:0] div_next;
    logic       frame_reg;
    logic       frame_next;
    logic       mframe_reg;
    logic       mframe_next;

    // Pulses come from logic on mclk, so no synchroniser is needed
    always_comb
    begin
        src_next    = sel_bus.source;
        div_next    = sel_bus.divide;
        frame_next  = frame_pulse_in & sync_reg[OCS_FRAME_BIT];
        mframe_next = multiframe_pulse_in & sync_reg[OCS_MFRAME_BIT];
    end

    // Reset values match the decode of the reset selector, no glitch at release
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            src_reg    <= OCS_SRC_PLL_A;
            div_reg    <= OCS_DIV_8;
            frame_reg  <= 1'b0;
            mframe_reg <= 1'b0;
        end
        else
        begin
            src_reg    <= src_next;
            div_reg    <= div_next;
            frame_reg  <= frame_next;
            mframe_reg <= mframe_next;
        end
    end

    assign clock_output_one_src = src_reg;
    assign clock_output_one_div = div_reg;
    assign frame_pulse_out      = frame_reg;
    assign multiframe_pulse_out = mframe_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    chk_sel_follows_write: assert property (
        reg_wr && reg_addr == OCS_ADDR_OUT_ONE && reg_wdata[7:4] == OCS_CODE_OFF
        |=> ##1 clock_output_one_src == OCS_SRC_OFF)
        else $error("output one not off after code zero");

    chk_pll_a_plain: assert property (
        reg_wr && reg_addr == OCS_ADDR_OUT_ONE && reg_wdata[7:4] == OCS_CODE_PLLA
        |=> ##1 clock_output_one_src == OCS_SRC_PLL_A && clock_output_one_div == OCS_DIV_1)
        else $error("undivided PLL A not selected");

    chk_pll_b_div64: assert property (
        reg_wr && reg_addr == OCS_ADDR_OUT_ONE && reg_wdata[7:4] == OCS_CODE_PLLB_D64
        |=> ##1 clock_output_one_src == OCS_SRC_PLL_B && clock_output_one_div == OCS_DIV_64)
        else $error("PLL B over 64 not selected");

    chk_readback_one: assert property (
        reg_wr && reg_addr == OCS_ADDR_OUT_ONE ##1 reg_rd && reg_addr == OCS_ADDR_OUT_ONE
        |=> reg_rdata == ($past(reg_wdata, 2) & OCS_OUT_ONE_MASK))
        else $error("output-one readback differs from write");

    chk_frame_gate: assert property (
        frame_pulse_out |-> $past(frame_pulse_in) && $past(sync_reg[OCS_FRAME_BIT]))
        else $error("frame pulse passed while disabled");

    chk_mframe_gate: assert property (
        $past(multiframe_pulse_in) && $past(sync_reg[OCS_MFRAME_BIT]) |-> multiframe_pulse_out)
        else $error("enabled multiframe pulse lost");

    chk_unused_zero: assert property (
        reg_rd |=> reg_rdata[3:0] == 4'h0 &&
                   (reg_rdata[5:4] == 2'h0 || $past(reg_addr) == OCS_ADDR_OUT_ONE))
        else $error("unused bits read non-zero");

    chk_2k_sel: assert property (
        reg_wr && reg_addr == OCS_ADDR_OUT_ONE && reg_wdata[7:4] == OCS_CODE_2K
        |=> ##1 clock_output_one_src == OCS_SRC_2K && clock_output_one_div == OCS_DIV_1)
        else $error("2 kHz source not selected");

    chk_synth_sel: assert property (
        reg_wr && reg_addr == OCS_ADDR_OUT_ONE && reg_wdata[7:4] == OCS_CODE_SYNTH_A
        |=> ##1 clock_output_one_src == OCS_SRC_SYNTH_A)
        else $error("synth clock not selected");

    chk_pll_a_div16: assert property (
        reg_wr && reg_addr == OCS_ADDR_OUT_ONE && reg_wdata[7:4] == OCS_CODE_PLLA_D16
        |=> ##1 clock_output_one_src == OCS_SRC_PLL_A && clock_output_one_div == OCS_DIV_16)
        else $error("PLL A over 16 not selected");

    chk_pll_b_div8: assert property (
        reg_wr && reg_addr == OCS_ADDR_OUT_ONE && reg_wdata[7:4] == OCS_CODE_PLLB_D8
        |=> ##1 clock_output_one_src == OCS_SRC_PLL_B && clock_output_one_div == OCS_DIV_8)
        else $error("PLL B over 8 not selected");

    chk_sync_write: assert property (
        reg_wr && reg_addr == OCS_ADDR_SYNC_EN
        |=> sync_reg == ($past(reg_wdata) & OCS_SYNC_MASK))
        else $error("sync enable write not stored");

    chk_frame_pass: assert property (
        frame_pulse_in && sync_reg[OCS_FRAME_BIT] |=> frame_pulse_out)
        else $error("enabled frame pulse lost");

    chk_mframe_block: assert property (
        multiframe_pulse_out |-> $past(multiframe_pulse_in) && $past(sync_reg[OCS_MFRAME_BIT]))
        else $error("multiframe pulse passed while disabled");

    // Writes elsewhere, including unmapped addresses, must leave both registers alone
    chk_reg_hold: assert property (
        !(reg_wr && (reg_addr == OCS_ADDR_OUT_ONE || reg_addr == OCS_ADDR_SYNC_EN))
        |=> $stable(out_one_reg) && $stable(sync_reg))
        else $error("register changed without a write");

    chk_rdata_hold: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    chk_read_sync: assert property (
        reg_rd && reg_addr == OCS_ADDR_SYNC_EN
        |=> reg_rdata == ($past(sync_reg) & OCS_SYNC_MASK))
        else $error("sync register readback wrong");

    chk_unused_bits: assert property (
        out_one_reg[3:0] == 4'h0 && sync_reg[5:0] == 6'h00)
        else $error("unused register bits hold ones");

    cov_sync_off:   cover property (reg_wr && reg_addr == OCS_ADDR_SYNC_EN && reg_wdata == 8'h00);
    cov_wr_then_rd: cover property (reg_wr ##1 reg_rd);
    cov_pll_b_sel:  cover property (clock_output_one_src == OCS_SRC_PLL_B);
    cov_mframe_out: cover property (multiframe_pulse_out);

endmodule : ocs_top

// *** bench/ocs_top_bench.sv ***
// Self-checking bench for the output clock select and sync enable block
`timescale 1ns/1ps
module ocs_top_bench
    import ocs_pkg::*;
;
    logic       mclk;
    logic       reset;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       fr_in;
    logic       mf_in;
    ocs_src_e   src;
    logic [6:0] div;
    logic       fr_out;
    logic       mf_out;
    logic [1:0] pin;
    logic [7:0] wval;
    int         n_errors;
    int         n_compared;
    int         cyc = 0;
    int         seed;
    // Reference model: source number (OFF=0 .. PLL_B=4) and ratio per code
    int         sr[16] = '{0, 1, 3, 0, 2, 3, 3, 3, 3, 3, 3, 4, 4, 0, 4, 4};
    int         dv[16] = '{1, 1, 2, 1, 1, 1, 16, 12, 8, 6, 4, 64, 48, 1, 8, 4};

    ocs_top dut
    (
        .mclk                 (mclk),
        .reset                (reset),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_rdata            (reg_rdata),
        .frame_pulse_in       (fr_in),
        .multiframe_pulse_in  (mf_in),
        .clock_output_one_src (src),
        .clock_output_one_div (div),
        .frame_pulse_out      (fr_out),
        .multiframe_pulse_out (mf_out)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Whole run is a few hundred cycles; ceiling leaves ample margin
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_errors++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Data is looked at a cycle late; it holds until the next read
    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        @(posedge mclk);
        #1;
        check(reg_rdata, exp);
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        reset      = 1'b1;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        reg_addr   = 8'h00;
        reg_wdata  = 8'h00;
        fr_in      = 1'b0;
        mf_in      = 1'b0;
        n_errors   = 0;
        n_compared = 0;
        seed       = $urandom(19);
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        #1;
        check({5'h00, src}, 8'h03);
        check({1'b0, div}, {1'b0, OCS_DIV_8});
        rd_chk(OCS_ADDR_OUT_ONE, 8'h80);
        rd_chk(OCS_ADDR_SYNC_EN, 8'hC0);
        $display("test reset values done");

        // Read issued on the cycle right after a write must return the new value
        wval = 8'($urandom);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= OCS_ADDR_OUT_ONE;
        reg_wdata <= wval;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge mclk);
        reg_rd    <= 1'b0;
        @(posedge mclk);
        #1;
        check(reg_rdata, wval & OCS_OUT_ONE_MASK);
        $display("test back-to-back access done");

        // Junk in the low nibble must not leak into readback
        for (int c = 0; c < 16; c++)
        begin
            wr(OCS_ADDR_OUT_ONE, {c[3:0], 4'($urandom)});
            repeat (2) @(posedge mclk);
            #1;
            check({5'h00, src}, 8'(sr[c]));
            check({1'b0, div}, 8'(dv[c]));
            rd_chk(OCS_ADDR_OUT_ONE, {c[3:0], 4'h0});
        end
        $display("test selector codes done");

        for (int e = 0; e < 4; e++)
        begin
            wr(OCS_ADDR_SYNC_EN, {e[1:0], 6'($urandom)});
            rd_chk(OCS_ADDR_SYNC_EN, {e[1:0], 6'h00});
            repeat (20)
            begin
                @(posedge mclk);
                pin = 2'($urandom);
                fr_in <= pin[0];
                mf_in <= pin[1];
                @(posedge mclk);
                #1;
                check({7'h00, fr_out}, {7'h00, pin[0] & e[0]});
                check({7'h00, mf_out}, {7'h00, pin[1] & e[1]});
            end
        end
        $display("test sync enables done");

        wr(8'h64, 8'hFF);
        rd_chk(8'h64, 8'h00);
        rd_chk(OCS_ADDR_OUT_ONE, 8'hF0);
        rd_chk(OCS_ADDR_SYNC_EN, 8'hC0);
        $display("test unmapped address done");
        report_and_stop();
    end
endmodule : ocs_top_bench
